// ==== hw/wdt_map.svh ====
// Register offsets, field positions, reset values and counting constants of the watchdog
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// Byte addresses on the register port
`define WDT_MODE_OFFSET 8'h00
`define WDT_RESTART_OFFSET 8'h04

// Mode register field positions
`define WDT_MODE_RSVD_BIT 7
`define WDT_MODE_ACT_HI_BIT 6
`define WDT_MODE_ACT_LO_BIT 5
`define WDT_MODE_SEL_MSB 4
`define WDT_MODE_SEL_LSB 0
`define WDT_SEL_SUB_BIT 4
`define WDT_SEL_MAIN_BIT 3

// Reset values and magic codes
`define WDT_MODE_RESET 8'h67
`define WDT_RESTART_READ 8'h9A
`define WDT_RESTART_KEY 8'hAC
`define WDT_UNMAPPED_READ 8'h00

// Base exponents of the three source clocks
`define WDT_EXP_BASE_INTOSC 5'h0C
`define WDT_EXP_BASE_MAIN 5'h12
`define WDT_EXP_BASE_SUB 5'h09

`endif

// ==== hw/wdt_pkg.sv ====
// Types shared by the watchdog design files
package wdt_pkg;

  // Register port request carried as one bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic byte_acc;
    logic bit_op;
  } bus_req_t;

  // Mode register layout
  typedef struct packed {
    logic rsvd;
    logic act_hi;
    logic act_lo;
    logic [4:0] sel;
  } mode_reg_t;

  // Decoded overflow action
  typedef enum logic [1:0] {
    ACT_STOP,
    ACT_NMI,
    ACT_RESET
  } action_t;

  // Selected counting source
  typedef enum logic [1:0] {
    SRC_INTOSC,
    SRC_MAIN,
    SRC_SUB
  } source_t;

endpackage : wdt_pkg

// ==== hw/wdt_counter.sv ====
// Power-of-two watchdog counter with registered overflow pulse
module wdt_counter #(
  parameter int CNT_W = 25
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_tick,
  input wire logic i_clear,
  input wire logic [4:0] i_exp,
  output logic o_ovf,
  output logic [CNT_W-1:0] o_count
);

  // Refuse widths that cannot hold the longest interval
  if (CNT_W < 25) begin : g_width_chk
    $error("wdt_counter: CNT_W must be at least 25");
  end

  // Terminal count for the selected exponent
  logic [CNT_W-1:0] last_cnt;
  logic [CNT_W-1:0] cnt_ff;
  logic ovf_ff;

  // Last value before wrap is two to the exponent minus one
  always_comb begin
    last_cnt = CNT_W'((CNT_W'(1) << i_exp) - CNT_W'(1));
  end

  // Count ticks, clear on restart or overflow
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_ff <= '0;
    end else if (i_clear) begin
      cnt_ff <= '0;
    end else if (i_tick) begin
      if (cnt_ff >= last_cnt) begin
        cnt_ff <= '0;
      end else begin
        cnt_ff <= cnt_ff + CNT_W'(1);
      end
    end
  end

  // One-cycle overflow pulse at the terminal tick
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ovf_ff <= 1'b0;
    end else begin
      ovf_ff <= i_tick && !i_clear && (cnt_ff >= last_cnt);
    end
  end

  assign o_ovf = ovf_ff;
  assign o_count = cnt_ff;

endmodule : wdt_counter

// ==== hw/default_start_watchdog.sv ====
// Default-start watchdog: mode and restart registers, counter control and overflow requests
//
// Overview of operation
// - Counter runs right after reset, no write.
// - Reset defaults: reset mode, oscillator, 2^19.
// - Overflow in reset mode requests system reset.
// - Overflow in interrupt mode requests NMI instead.
// - Action bits: 00 stop, 01 NMI, 1x reset.
// - Mode resets 67H, bit7 zero, fields.
// - Mode register byte only, written once.
// - Second mode write forces overflow, clears counter.
// - Stopped mode suppresses every forced overflow.
// - Source clock: main, oscillator or subclock.
// - Select field picks source and exponent.
// - Forbidden-clock mode access stalls until reset.
// - Writing ACH restarts the counter.
// - Other value or bit operation forces overflow.
// - Restart register reads 9AH, 00H once the bus stalls.
// - Reset-mode overflow during stabilisation switches CPU clock.
//
// Our own choices: the strobed register port and the placing of the registers.
`include "wdt_map.svh"

module default_start_watchdog #(
  parameter int CNT_W = 25
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  // Register port request bundle
  input wire wdt_pkg::bus_req_t i_bus,
  // Source clock ticks, one cycle each
  input wire logic i_intosc_tick,
  input wire logic i_main_tick,
  input wire logic i_sub_tick,
  // System status for access and overflow handling
  input wire logic i_cpu_sub_main_stop,
  input wire logic i_cpu_on_intosc,
  input wire logic i_osc_stabilising,
  // Register read data, valid the cycle after a read
  output logic [7:0] o_rdata,
  // Overflow requests to reset and NMI logic
  output logic o_watchdog_reset_req,
  output logic o_watchdog_nmi_req,
  output logic o_cpu_clk_to_intosc,
  // Bus held in a wait that only reset releases
  output logic o_bus_stall,
  // Watchdog counting
  output logic o_running
);

  // Refuse widths that cannot hold the longest interval
  if (CNT_W < 25) begin : g_width_chk
    $error("default_start_watchdog: CNT_W must be at least 25");
  end

  // Mode register contents
  wdt_pkg::mode_reg_t mode_ff;
  // First byte write already taken
  logic mode_written_ff;
  // Sticky wait status
  logic stall_ff;
  // Output registers, one per top-level output
  // Read data register
  logic [7:0] rdata_ff;
  // Reset request pulse
  logic reset_req_ff;
  // NMI request pulse
  logic nmi_req_ff;
  // Clock switch pulse
  logic clk_switch_ff;
  // Counting status
  logic running_ff;
  // Registered forced overflow request
  logic force_ff;

  // Decoded mode fields
  // Overflow action
  wdt_pkg::action_t action;
  // Counting source
  wdt_pkg::source_t source;
  // Interval as a power of two
  logic [4:0] exponent;
  // Tick of the selected source
  logic tick;

  // Address hits
  // Mode register addressed
  logic hit_mode;
  // Restart register addressed
  logic hit_restart;
  // CPU clock state bars mode access
  logic forbidden_clk;
  // Mode access may proceed
  logic access_ok;

  // Write events
  // Legal byte write to the mode register
  logic mode_wr;
  // First such write since reset
  logic mode_first_wr;
  // Any later such write
  logic mode_again_wr;
  // Write to the restart register
  logic restart_wr;
  // Restart with the correct key
  logic restart_key;
  // Restart with a wrong value or bit operation
  logic restart_bad;
  // Next value of the forced overflow flag
  logic nxt_force;

  // Counter interface
  // Clear request to the counter
  logic cnt_clear;
  // Natural overflow pulse from the counter
  logic cnt_ovf;
  // Natural or forced overflow
  logic overflow;

  // Action decode from the two action bits
  always_comb begin
    if (mode_ff.act_hi) begin
      // High bit set: reset whatever the low bit
      action = wdt_pkg::ACT_RESET;
    end else if (mode_ff.act_lo) begin
      // Low bit alone: interrupt mode
      action = wdt_pkg::ACT_NMI;
    end else begin
      // Both clear: watchdog stopped
      action = wdt_pkg::ACT_STOP;
    end
  end

  // Source and exponent decode from the select field
  always_comb begin
    if (mode_ff.sel[`WDT_SEL_SUB_BIT]) begin
      // Subclock, bit 3 ignored
      source = wdt_pkg::SRC_SUB;
      exponent = 5'(`WDT_EXP_BASE_SUB + {2'h0, mode_ff.sel[2:0]});
    end else if (mode_ff.sel[`WDT_SEL_MAIN_BIT]) begin
      // Main clock
      source = wdt_pkg::SRC_MAIN;
      exponent = 5'(`WDT_EXP_BASE_MAIN + {2'h0, mode_ff.sel[2:0]});
    end else begin
      // Internal oscillator
      source = wdt_pkg::SRC_INTOSC;
      exponent = 5'(`WDT_EXP_BASE_INTOSC + {2'h0, mode_ff.sel[2:0]});
    end
  end

  // Tick of the selected source, blocked while stopped
  always_comb begin
    // Pick the tick of the selected source
    case (source)
      wdt_pkg::SRC_SUB: begin
        tick = i_sub_tick;
      end
      wdt_pkg::SRC_MAIN: begin
        tick = i_main_tick;
      end
      default: begin
        tick = i_intosc_tick;
      end
    endcase
    // Stopped mode blocks every tick
    if (action == wdt_pkg::ACT_STOP) begin
      tick = 1'b0;
    end
  end

  // Address decode
  always_comb begin
    // Default: no register hit
    hit_mode = 1'b0;
    hit_restart = 1'b0;
    if (i_bus.addr == `WDT_MODE_OFFSET) begin
      // Mode register
      hit_mode = 1'b1;
    end else if (i_bus.addr == `WDT_RESTART_OFFSET) begin
      // Restart register
      hit_restart = 1'b1;
    end
  end

  // Mode register is unreachable in the forbidden clock states
  always_comb begin
    forbidden_clk = i_cpu_sub_main_stop || i_cpu_on_intosc;
    access_ok = !stall_ff && !(hit_mode && forbidden_clk);
  end

  // Write event decode
  always_comb begin
    // Mode writes need byte access and a legal clock
    mode_wr = i_bus.wr && hit_mode && access_ok && i_bus.byte_acc;
    // First write loads, later ones only force
    mode_first_wr = mode_wr && !mode_written_ff;
    mode_again_wr = mode_wr && mode_written_ff;
    // Restart register reachable in any clock state
    restart_wr = i_bus.wr && hit_restart && !stall_ff;
    restart_key = restart_wr && !i_bus.bit_op && (i_bus.wdata == `WDT_RESTART_KEY);
    // Anything but the key is a bad restart
    restart_bad = restart_wr && !restart_key;
    // Forced overflow only while the watchdog is not stopped
    nxt_force = (mode_again_wr || restart_bad) && (action != wdt_pkg::ACT_STOP);
  end

  // Counter clears on restart, forced overflow and mode load
  always_comb begin
    cnt_clear = restart_key || nxt_force || mode_first_wr;
  end

  // Natural or forced overflow event
  always_comb begin
    overflow = (cnt_ovf && (action != wdt_pkg::ACT_STOP)) || force_ff;
  end

  // Mode register, loaded by the first byte write only
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_ff <= `WDT_MODE_RESET;
    end else if (mode_first_wr) begin
      // Reserved bit always stored as zero
      mode_ff.rsvd <= 1'b0;
      mode_ff.act_hi <= i_bus.wdata[`WDT_MODE_ACT_HI_BIT];
      mode_ff.act_lo <= i_bus.wdata[`WDT_MODE_ACT_LO_BIT];
      mode_ff.sel <= i_bus.wdata[`WDT_MODE_SEL_MSB:`WDT_MODE_SEL_LSB];
    end
  end

  // Write-once marker
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_written_ff <= 1'b0;
    end else if (mode_first_wr) begin
      // Later writes never reload the mode
      mode_written_ff <= 1'b1;
    end
  end

  // Sticky wait, released only by reset
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      stall_ff <= 1'b0;
    end else if ((i_bus.wr || i_bus.rd) && hit_mode && forbidden_clk) begin
      // Wait holds until the next reset
      stall_ff <= 1'b1;
    end
  end

  // Forced overflow takes effect one cycle after the write
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      force_ff <= 1'b0;
    end else begin
      // Already gated off in stopped mode
      force_ff <= nxt_force;
    end
  end

  // Read data, present only in the cycle after the strobe
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_ff <= 8'h00;
    end else if (i_bus.rd && !stall_ff) begin
      if (hit_mode && access_ok && i_bus.byte_acc) begin
        // Reserved bit reads zero
        rdata_ff <= {1'b0, mode_ff.act_hi, mode_ff.act_lo, mode_ff.sel};
      end else if (hit_restart) begin
        // Fixed pattern, whatever was written
        rdata_ff <= `WDT_RESTART_READ;
      end else begin
        // Unmapped or refused access
        rdata_ff <= `WDT_UNMAPPED_READ;
      end
    end else begin
      // Quiet bus reads back zero
      rdata_ff <= 8'h00;
    end
  end

  // Reset request pulse, withheld during oscillation stabilisation
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      reset_req_ff <= 1'b0;
    end else begin
      // Held back while the oscillator settles
      reset_req_ff <= overflow && (action == wdt_pkg::ACT_RESET) && !i_osc_stabilising;
    end
  end

  // Clock switch pulse in place of reset during stabilisation
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      clk_switch_ff <= 1'b0;
    end else begin
      // Only while the oscillator settles
      clk_switch_ff <= overflow && (action == wdt_pkg::ACT_RESET) && i_osc_stabilising;
    end
  end

  // NMI request pulse
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      nmi_req_ff <= 1'b0;
    end else begin
      // Interrupt mode only
      nmi_req_ff <= overflow && (action == wdt_pkg::ACT_NMI);
    end
  end

  // Running status, counting from reset release
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      running_ff <= 1'b0;
    end else begin
      // Stopped mode is the only idle state
      running_ff <= (action != wdt_pkg::ACT_STOP);
    end
  end

  // Counter starts counting right after reset, no write needed
  wdt_counter #(
    .CNT_W(CNT_W)
  ) u_counter (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_tick(tick),
    .i_clear(cnt_clear),
    .i_exp(exponent),
    .o_ovf(cnt_ovf),
    // Count value is not needed here
    .o_count()
  );

  // Every output straight from its register
  assign o_rdata = rdata_ff;
  assign o_watchdog_reset_req = reset_req_ff;
  assign o_watchdog_nmi_req = nmi_req_ff;
  assign o_cpu_clk_to_intosc = clk_switch_ff;
  assign o_bus_stall = stall_ff;
  assign o_running = running_ff;

endmodule : default_start_watchdog

// ==== dv/wdt_far_side.sv ====
// Far-side model: reset and NMI logic counting watchdog requests
module wdt_far_side (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_reset_req,
  input wire logic i_nmi_req,
  input wire logic i_clk_switch,
  output int o_reset_cnt,
  output int o_nmi_cnt,
  output int o_switch_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // Count each one-cycle request; system reset clears the tallies
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reset_cnt <= 0;
      o_nmi_cnt <= 0;
      o_switch_cnt <= 0;
    end else begin
      o_reset_cnt <= o_reset_cnt + int'(i_reset_req);
      o_nmi_cnt <= o_nmi_cnt + int'(i_nmi_req);
      o_switch_cnt <= o_switch_cnt + int'(i_clk_switch);
    end
  end
endmodule : wdt_far_side

// ==== dv/default_start_watchdog_sva.sv ====
// Port-level checks of the watchdog
module default_start_watchdog_sva (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire wdt_pkg::bus_req_t i_bus,
  input wire logic i_cpu_sub_main_stop,
  input wire logic i_cpu_on_intosc,
  input wire logic [7:0] o_rdata,
  input wire logic o_watchdog_reset_req,
  input wire logic o_watchdog_nmi_req,
  input wire logic o_cpu_clk_to_intosc,
  input wire logic o_bus_stall,
  input wire logic o_running
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // Any overflow outcome
  logic any_req;
  assign any_req = o_watchdog_reset_req | o_watchdog_nmi_req | o_cpu_clk_to_intosc;
  // Mode register touched on the bus
  logic mode_acc;
  assign mode_acc = (i_bus.wr | i_bus.rd) && (i_bus.addr == 8'h00);
  a_rst_pulse_one: assert property (o_watchdog_reset_req |=> !o_watchdog_reset_req)
    else $error("reset request longer than one cycle");
  a_nmi_pulse_one: assert property (o_watchdog_nmi_req |=> !o_watchdog_nmi_req)
    else $error("nmi request longer than one cycle");
  a_one_req_kind: assert property (!(o_watchdog_reset_req && o_watchdog_nmi_req))
    else $error("reset and nmi requests together");
  a_restart_reads: assert property ((i_bus.rd && i_bus.addr == 8'h04 && !o_bus_stall)
    |=> o_rdata == 8'h9A) else $error("restart register read wrong");
  a_bad_key_force: assert property ((i_bus.wr && i_bus.addr == 8'h04 && o_running
    && !o_bus_stall && (i_bus.wdata != 8'hAC || i_bus.bit_op)) |-> ##2 any_req)
    else $error("bad restart key gave no overflow");
  a_stop_silent: assert property ((!o_running) [*3] |-> !any_req)
    else $error("request while stopped");
  a_stall_sticky: assert property (o_bus_stall |=> o_bus_stall)
    else $error("bus wait released without reset");
  a_stall_cause: assert property ($rose(o_bus_stall)
    |-> $past(mode_acc && (i_cpu_sub_main_stop || i_cpu_on_intosc)))
    else $error("bus wait without forbidden access");
  a_run_at_start: assert property ($rose(i_nrst) |=> o_running)
    else $error("counter not running after reset");
  c_reset_req: cover property (o_watchdog_reset_req);
  c_nmi_req: cover property (o_watchdog_nmi_req);
  c_clk_switch: cover property (o_cpu_clk_to_intosc);
  c_stall: cover property ($rose(o_bus_stall));
endmodule : default_start_watchdog_sva
bind default_start_watchdog default_start_watchdog_sva chk (.i_mclk(i_mclk), .i_nrst(i_nrst),
  .i_bus(i_bus), .i_cpu_sub_main_stop(i_cpu_sub_main_stop), .i_cpu_on_intosc(i_cpu_on_intosc),
  .o_rdata(o_rdata), .o_watchdog_reset_req(o_watchdog_reset_req),
  .o_watchdog_nmi_req(o_watchdog_nmi_req), .o_cpu_clk_to_intosc(o_cpu_clk_to_intosc),
  .o_bus_stall(o_bus_stall), .o_running(o_running));

// ==== dv/test_default_start_watchdog.sv ====
// Self-checking bench for the default-start watchdog
module test_default_start_watchdog;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_mclk, i_nrst; // Clock and reset
  wdt_pkg::bus_req_t bus; // Register port request
  logic os_tk, mn_tk, sb_tk; // Source ticks
  logic sub_stop, on_osc, stab; // System status
  logic [7:0] rdata; // Read data
  logic rst_req, nmi_req, clk_sw, stall, run; // Design outputs
  int rst_n, nmi_n, sw_n; // Far-side tallies
  int num_errors = 0;
  int n_tests = 0;
  // Action table: reset, NMI, reset (low bit set), stop written as 00
  // Third code sets the ignored subclock bit 3
  logic [7:0] codes [4] = '{8'hD0, 8'h30, 8'h78, 8'h00};
  int er [4] = '{1, 0, 1, 0};
  int en [4] = '{0, 1, 0, 0};
  default_start_watchdog dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_bus(bus),
    .i_intosc_tick(os_tk), .i_main_tick(mn_tk), .i_sub_tick(sb_tk),
    .i_cpu_sub_main_stop(sub_stop), .i_cpu_on_intosc(on_osc), .i_osc_stabilising(stab),
    .o_rdata(rdata), .o_watchdog_reset_req(rst_req), .o_watchdog_nmi_req(nmi_req),
    .o_cpu_clk_to_intosc(clk_sw), .o_bus_stall(stall), .o_running(run));
  wdt_far_side far (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_reset_req(rst_req),
    .i_nmi_req(nmi_req), .i_clk_switch(clk_sw), .o_reset_cnt(rst_n), .o_nmi_cnt(nmi_n),
    .o_switch_cnt(sw_n));
  // 40 MHz clock
  initial begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  // Compare and tally
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen %0h want %0h", $time, seen, exp);
    end
  endtask : chk
  // Reset held 12 cycles
  task rst;
    i_nrst <= 1'b0;
    repeat (12) @(posedge i_mclk);
    i_nrst <= 1'b1;
  endtask : rst
  // One-cycle write, then room for a forced request to land
  task wr(input logic [7:0] a, input logic [7:0] d, input logic bo);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, byte_acc: 1'b1, bit_op: bo};
    @(posedge i_mclk);
    bus <= '0;
    repeat (3) @(posedge i_mclk);
  endtask : wr
  // One-cycle read; data checked in the following cycle
  task rd(input logic [7:0] a, input logic ba, input logic [7:0] exp);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1, byte_acc: ba, bit_op: 1'b0};
    @(posedge i_mclk);
    bus <= '0;
    #1 chk(rdata, exp);
    @(posedge i_mclk);
  endtask : rd
  // Subclock ticks every other cycle, then settle
  task tk(input int n);
    repeat (n) begin
      @(posedge i_mclk);
      sb_tk <= 1'b1;
      @(posedge i_mclk);
      sb_tk <= 1'b0;
    end
    repeat (3) @(posedge i_mclk);
  endtask : tk
  // Verdict
  task results;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  initial begin
    i_nrst = 1'b0;
    bus = '0;
    {os_tk, mn_tk, sb_tk, sub_stop, on_osc, stab} = 6'h00;
    rst();
    os_tk <= 1'b1;
    mn_tk <= 1'b1;
    rd(8'h00, 1'b1, 8'h67);
    chk(run, 1'b1);
    rd(8'h04, 1'b1, 8'h9A);
    rd(8'h00, 1'b0, 8'h00);
    rd(8'h08, 1'b1, 8'h00);
    wr(8'h00, 8'hD0, 1'b0);
    rd(8'h00, 1'b1, 8'h50);
    tk(300);
    wr(8'h04, 8'hAC, 1'b0);
    tk(511);
    chk(rst_n, 0);
    tk(1);
    chk(rst_n, 1);
    wr(8'h00, 8'h30, 1'b0);
    chk(rst_n, 2);
    rd(8'h00, 1'b1, 8'h50);
    wr(8'h04, 8'hAC, 1'b1);
    chk(rst_n, 3);
    stab <= 1'b1;
    wr(8'h04, 8'h55, 1'b0);
    chk(sw_n, 1);
    chk(rst_n, 3);
    stab <= 1'b0;
    $display("test defaults and restart done");
    foreach (codes[i]) begin
      rst();
      wr(8'h00, codes[i], 1'b0);
      tk(511);
      chk(rst_n + nmi_n, 0);
      tk(1);
      chk(rst_n, er[i]);
      chk(nmi_n, en[i]);
      wr(8'h04, 8'h55, 1'b0);
      chk(rst_n + nmi_n, 2 * (er[i] + en[i]));
      wr(8'h00, 8'h67, 1'b0);
      chk(rst_n + nmi_n, 3 * (er[i] + en[i]));
      chk(run, codes[i][6] | codes[i][5]);
    end
    $display("test action codes done");
    rst();
    on_osc <= 1'b1;
    rd(8'h00, 1'b1, 8'h00);
    on_osc <= 1'b0;
    rd(8'h04, 1'b1, 8'h00);
    chk(stall, 1'b1);
    rst();
    chk(stall, 1'b0);
    sub_stop <= 1'b1;
    wr(8'h00, 8'h30, 1'b0);
    chk(stall, 1'b1);
    $display("test bus wait done");
    // Oscillator source, shortest interval: 4096 ticks, one per cycle
    rst();
    sub_stop <= 1'b0;
    wr(8'h00, 8'h40, 1'b0);
    repeat (4092) @(posedge i_mclk);
    chk(rst_n, 0);
    repeat (4) @(posedge i_mclk);
    chk(rst_n, 1);
    // Main clock source: far longer interval, no overflow yet
    rst();
    wr(8'h00, 8'h48, 1'b0);
    repeat (4100) @(posedge i_mclk);
    chk(rst_n + nmi_n, 0);
    $display("test clock sources done");
    results();
  end
  // Hang guard
  initial begin
    repeat (60000) @(posedge i_mclk);
    num_errors++;
    results();
  end
endmodule : test_default_start_watchdog
